// *** core/mdcfg_pkg.sv ***
package mdcfg_pkg;

  // Clock and analogue timing figures
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned BLANK_LONG_NS = 1800;
  localparam int unsigned BLANK_SHORT_NS = 1000;
  localparam int unsigned DEGLITCH_LONG_NS = 2000;
  localparam int unsigned DEGLITCH_SHORT_NS = 1000;
  localparam int unsigned CYC_W = 6;
  // Least times, so round up
  localparam logic [CYC_W-1:0] BLANK_LONG_CYC = CYC_W'((BLANK_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CYC_W-1:0] BLANK_SHORT_CYC = CYC_W'((BLANK_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CYC_W-1:0] DEGLITCH_LONG_CYC = CYC_W'((DEGLITCH_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CYC_W-1:0] DEGLITCH_SHORT_CYC = CYC_W'((DEGLITCH_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Register offsets
  localparam logic [7:0] OFS_CLEAR_CMD = 8'h09;
  localparam logic [7:0] OFS_INRUSH_LOW = 8'h0a;
  localparam logic [7:0] OFS_INRUSH_HIGH = 8'h0b;
  localparam logic [7:0] OFS_MODE_TIMING = 8'h0c;
  localparam logic [7:0] OFS_REPORT_BRIDGE = 8'h0d;

  // Reset values
  localparam logic [7:0] RST_INRUSH_LOW = 8'h00;
  localparam logic [7:0] RST_INRUSH_HIGH = 8'h00;
  localparam logic [7:0] RST_MODE_TIMING = 8'h63;
  localparam logic [7:0] RST_REPORT_BRIDGE = 8'h38;

  // mode_and_timing_config fields
  localparam int unsigned MT_BEHAV_HI = 7;
  localparam int unsigned MT_BEHAV_LO = 6;
  localparam int unsigned MT_STALL_RESP = 5;
  localparam int unsigned MT_INT_VREF = 4;
  localparam int unsigned MT_BLANK_SEL = 3;
  localparam int unsigned MT_DEGLITCH_SEL = 2;
  localparam int unsigned MT_OC_RESP = 1;
  localparam int unsigned MT_OT_RESP = 0;

  // report_and_bridge_config fields
  localparam int unsigned RB_RIPPLE_HI = 7;
  localparam int unsigned RB_RIPPLE_LO = 6;
  localparam int unsigned RB_STALL_REPORT_BIT = 5;
  localparam int unsigned RB_CYCLE_REP = 4;
  localparam int unsigned RB_INPUT_MODE = 3;
  localparam int unsigned RB_SOURCE = 2;
  localparam int unsigned RB_INPUT_A = 1;
  localparam int unsigned RB_INPUT_B = 0;

  // Clear command bits
  localparam int unsigned CMD_CLR_COUNT = 2;
  localparam int unsigned CMD_CLR_FAULTS = 1;

  // Ripple report encodings and regulation scheme
  localparam logic [1:0] RIPPLE_NONE = 2'h0;
  localparam logic [1:0] RIPPLE_LEVEL = 2'h1;
  localparam logic [1:0] RIPPLE_LATCH = 2'h2;
  localparam logic [1:0] RIPPLE_SATURATE = 2'h3;
  localparam logic [1:0] SCHEME_CBC = 2'h1;

  // Serial byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8;

endpackage

// *** core/mdcfg_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module mdcfg_sync #(
  parameter int W = 1
) (
  input wire logic i_clk, // Block clock
  input wire logic i_rst, // Sync reset
  input wire logic [W-1:0] i_async, // Foreign-domain levels
  output logic [W-1:0] o_sync // Two-stage result
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } mdcfg_sync_s;

  mdcfg_sync_s q;
  mdcfg_sync_s d;

  always_comb begin
    d.meta = i_async;
    d.stable = q.meta;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.stable;
endmodule
`default_nettype wire

// *** core/mdcfg_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
module mdcfg_timer #(
  parameter int W = 16
) (
  input wire logic i_clk, // Block clock
  input wire logic i_rst, // Sync reset
  input wire logic i_tick, // Count enable pulse
  input wire logic i_load, // Restart with i_value
  input wire logic [W-1:0] i_value, // Ticks to run
  output logic o_busy // Counting
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } mdcfg_timer_s;

  mdcfg_timer_s q;
  mdcfg_timer_s d;

  always_comb begin
    d = q;
    if (i_load) begin
      d.cnt = i_value;
    end else if (i_tick && q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_busy = (q.cnt != '0);
endmodule
`default_nettype wire

// *** core/mdcfg_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Inrush blank time is {inrush_time_high, inrush_time_low}, sixteen bits.
// - Stall is not declared while the inrush blank timer runs after start.
// - Current regulation behaviour field in bits 7:6, reset value 1.
// - Stall response bit 5 selects stall reaction, resets to 1.
// - Internal reference bit set fixes reference at 500mV internally.
// - Sense blanking 1.8us when select bit 0, 1.0us when 1.
// - Deglitch 2us when select bit 0, 1us when 1.
// - Overcurrent with response bit 0 latches outputs off until clear faults.
// - Overcurrent with response bit 1 turns bridge off and retries after retry time.
// - Overtemperature latches off with bit 0; resumes when event clears with bit 1.
// - Ripple report field decides ripple fault reporting and count saturation.
// - Stall report bit 1 holds fault low during stall; bit 0 ignores stall.
// - In cycle-by-cycle mode, cycle report bit pulls fault low during regulation.
// - Bridge input mode: 0 phase/enable, 1 PWM; resets to 1.
// - Bridge source: 0 input pins, 1 register bits; resets to 0.
// - Register input bit 1 drives bridge input A only when source is register.
// - Register input bit 0 drives bridge input B only when source is register.
// - Writing 1 to clear faults clears latched faults; bit self-clears.
// - Clear count also releases ripple fault when report field is 10b.
// - Regulation scheme 01b selects cycle-by-cycle mode.
module mdcfg_top #(
  parameter logic [6:0] DEV_ADDR = 7'h30, // Arbitrary follower address
  parameter int TICK_W = 16,
  parameter int TICK_CYCLES = 20, // Clock cycles per inrush or retry tick
  parameter logic [15:0] RETRY_TICKS = 16'h03e8 // Retry time in ticks
) (
  input wire logic I_CLK, // 20 MHz clock
  input wire logic I_RST, // Sync reset, active high
  input wire logic I_SCL, // Serial clock pin
  input wire logic I_SDA, // Serial data pin level
  input wire logic [1:0] I_BRIDGE_INPUT_PINS, // [1]=A enable/PWM, [0]=B phase/PWM
  input wire logic I_MOTOR_RUN, // Motor running level
  input wire logic I_STALL_RAW, // Raw stall detector
  input wire logic I_OVERCURRENT_EVENT, // Overcurrent level
  input wire logic I_OVERTEMP_EVENT, // Overtemperature level, with hysteresis
  input wire logic I_RIPPLE_OVER, // Ripple count over threshold
  input wire logic I_CBC_REGULATING, // Bridge in internal regulation
  input wire logic [1:0] I_REG_SCHEME, // Regulation scheme field
  output logic O_SDA_OUT, // Data drive value, always 0
  output logic O_SDA_OE, // Data pulled low when high
  output logic O_FAULT_OUT_N, // Fault output, active low
  output logic O_BRIDGE_A, // Bridge input A
  output logic O_BRIDGE_B, // Bridge input B
  output logic O_BRIDGE_INPUT_MODE, // 0 phase/enable, 1 PWM
  output logic [1:0] O_CURRENT_REG_BEHAVIOUR, // Current regulation behaviour
  output logic O_STALL_RESPONSE_SELECT, // Stall response select
  output logic O_INT_VREF, // Fix reference internally
  output logic [5:0] O_SENSE_BLANK_CYCLES, // Sense blanking in cycles
  output logic [5:0] O_DEGLITCH_CYCLES, // Deglitch in cycles
  output logic O_STALL_DETECTED, // Stall after inrush blanking
  output logic O_BRIDGE_OFF, // Bridge forced off
  output logic O_CLEAR_COUNT, // Ripple counter clear pulse
  output logic O_RIPPLE_SATURATE // Ripple count saturates at max
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } mdcfg_state_e;

  typedef struct packed {
    mdcfg_state_e st;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic [3:0] bitcnt;
    logic rw;
    logic sda_oe;
    logic sda_out;
    logic scl_prev;
    logic sda_prev;
    logic [7:0] inrush_lo;
    logic [7:0] inrush_hi;
    logic [7:0] mode_cfg;
    logic [7:0] report_cfg;
    logic clr_faults;
    logic clr_count;
    logic [TICK_W-1:0] div_cnt;
    logic tick;
    logic run_prev;
    logic inrush_load;
    logic retry_load;
    logic stall;
    logic ocp_latched;
    logic ots_latched;
    logic ripple_latched;
    logic bridge_off;
    logic fault_n;
    logic bridge_a;
    logic bridge_b;
    logic ripple_sat;
    logic [5:0] blank_cyc;
    logic [5:0] deg_cyc;
  } mdcfg_regs_s;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  mdcfg_regs_s q;
  mdcfg_regs_s d;
  logic [3:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic inrush_busy;
  logic retry_busy;
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic [1:0] ripple_field;
  logic ripple_src;
  logic stall_src;
  logic cbc_src;

  function automatic logic [7:0] rd_reg(input logic [7:0] ofs, input mdcfg_regs_s r);
    logic [7:0] v;
    v = 8'h00;
    if (ofs == mdcfg_pkg::OFS_INRUSH_LOW) begin
      v = r.inrush_lo;
    end else if (ofs == mdcfg_pkg::OFS_INRUSH_HIGH) begin
      v = r.inrush_hi;
    end else if (ofs == mdcfg_pkg::OFS_MODE_TIMING) begin
      v = r.mode_cfg;
    end else if (ofs == mdcfg_pkg::OFS_REPORT_BRIDGE) begin
      v = r.report_cfg;
    end
    return v;
  endfunction

  // Bus pins and bridge pins are foreign to I_CLK
  mdcfg_sync #(.W(4)) u_sync (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_async({I_SCL, I_SDA, I_BRIDGE_INPUT_PINS}),
    .o_sync(pins_s)
  );

  mdcfg_timer #(.W(16)) u_inrush (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_tick(q.tick),
    .i_load(q.inrush_load),
    .i_value({q.inrush_hi, q.inrush_lo}),
    .o_busy(inrush_busy)
  );

  mdcfg_timer #(.W(16)) u_retry (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_tick(q.tick),
    .i_load(q.retry_load),
    .i_value(RETRY_TICKS),
    .o_busy(retry_busy)
  );

  assign scl_s = pins_s[3];
  assign sda_s = pins_s[2];
  assign start_cond = q.scl_prev && scl_s && q.sda_prev && !sda_s;
  assign stop_cond = q.scl_prev && scl_s && !q.sda_prev && sda_s;
  assign scl_rise = !q.scl_prev && scl_s;
  assign scl_fall = q.scl_prev && !scl_s;
  assign ripple_field = q.report_cfg[mdcfg_pkg::RB_RIPPLE_HI:mdcfg_pkg::RB_RIPPLE_LO];
  assign ripple_src = q.ripple_latched || (I_RIPPLE_OVER && (ripple_field == mdcfg_pkg::RIPPLE_LEVEL ||
                      ripple_field == mdcfg_pkg::RIPPLE_SATURATE));
  assign stall_src = q.stall && q.report_cfg[mdcfg_pkg::RB_STALL_REPORT_BIT];
  assign cbc_src = (I_REG_SCHEME == mdcfg_pkg::SCHEME_CBC) && q.report_cfg[mdcfg_pkg::RB_CYCLE_REP] &&
                   I_CBC_REGULATING;

  always_comb begin
    d = q;
    d.scl_prev = scl_s;
    d.sda_prev = sda_s;
    d.clr_faults = 1'b0;
    d.clr_count = 1'b0;
    d.sda_out = 1'b0;
    // Tick divider for the inrush and retry timers
    if (q.div_cnt == TICK_LAST) begin
      d.div_cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.div_cnt = q.div_cnt + 1'b1;
      d.tick = 1'b0;
    end
    // Serial follower; data only changes while the clock is low
    if (start_cond) begin
      d.st = ST_ADDR;
      d.bitcnt = '0;
      d.sda_oe = 1'b0;
    end else if (stop_cond) begin
      d.st = ST_IDLE;
      d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (q.st)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          d.shreg = {q.shreg[6:0], sda_s};
          d.bitcnt = q.bitcnt + 1'b1;
        end
        ST_RDATA: begin
          d.bitcnt = q.bitcnt + 1'b1;
        end
        ST_RDATA_ACK: begin
          // Controller NACK ends the read
          if (sda_s) begin
            d.st = ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (q.st)
        ST_ADDR: begin
          if (q.bitcnt == mdcfg_pkg::BYTE_BITS) begin
            if (q.shreg[7:1] == DEV_ADDR) begin
              d.st = ST_ADDR_ACK;
              d.rw = q.shreg[0];
              d.sda_oe = 1'b1;
            end else begin
              d.st = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          d.bitcnt = '0;
          if (q.rw) begin
            d.st = ST_RDATA;
            d.tx = rd_reg(q.ptr, q);
            d.sda_oe = !d.tx[7];
          end else begin
            d.st = ST_PTR;
            d.sda_oe = 1'b0;
          end
        end
        ST_PTR: begin
          if (q.bitcnt == mdcfg_pkg::BYTE_BITS) begin
            d.ptr = q.shreg;
            d.st = ST_PTR_ACK;
            d.sda_oe = 1'b1;
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK: begin
          d.st = ST_WDATA;
          d.bitcnt = '0;
          d.sda_oe = 1'b0;
        end
        ST_WDATA: begin
          if (q.bitcnt == mdcfg_pkg::BYTE_BITS) begin
            d.st = ST_WDATA_ACK;
            d.sda_oe = 1'b1;
            d.ptr = q.ptr + 1'b1;
            if (q.ptr == mdcfg_pkg::OFS_CLEAR_CMD) begin
              d.clr_faults = q.shreg[mdcfg_pkg::CMD_CLR_FAULTS];
              d.clr_count = q.shreg[mdcfg_pkg::CMD_CLR_COUNT];
            end else if (q.ptr == mdcfg_pkg::OFS_INRUSH_LOW) begin
              d.inrush_lo = q.shreg;
            end else if (q.ptr == mdcfg_pkg::OFS_INRUSH_HIGH) begin
              d.inrush_hi = q.shreg;
            end else if (q.ptr == mdcfg_pkg::OFS_MODE_TIMING) begin
              d.mode_cfg = q.shreg;
            end else if (q.ptr == mdcfg_pkg::OFS_REPORT_BRIDGE) begin
              d.report_cfg = q.shreg;
            end
          end
        end
        ST_RDATA: begin
          if (q.bitcnt == mdcfg_pkg::BYTE_BITS) begin
            d.st = ST_RDATA_ACK;
            d.sda_oe = 1'b0;
            d.ptr = q.ptr + 1'b1;
          end else begin
            d.tx = {q.tx[6:0], 1'b0};
            d.sda_oe = !q.tx[6];
          end
        end
        ST_RDATA_ACK: begin
          d.st = ST_RDATA;
          d.bitcnt = '0;
          d.tx = rd_reg(q.ptr, q);
          d.sda_oe = !d.tx[7];
        end
        default: begin
        end
      endcase
    end
    // Motor start arms the inrush blanking
    d.run_prev = I_MOTOR_RUN;
    d.inrush_load = I_MOTOR_RUN && !q.run_prev;
    // Start and load cycles covered too, since the timer is busy two cycles later
    d.stall = I_STALL_RAW && !inrush_busy && !q.inrush_load && !d.inrush_load;
    // Set wins over clear on every latched flag
    d.ocp_latched = (I_OVERCURRENT_EVENT && !q.mode_cfg[mdcfg_pkg::MT_OC_RESP]) ||
                    (q.ocp_latched && !q.clr_faults);
    d.retry_load = I_OVERCURRENT_EVENT && q.mode_cfg[mdcfg_pkg::MT_OC_RESP];
    d.ots_latched = (I_OVERTEMP_EVENT && !q.mode_cfg[mdcfg_pkg::MT_OT_RESP]) ||
                    (q.ots_latched && !q.clr_faults);
    d.bridge_off = d.ocp_latched || d.ots_latched || d.retry_load || retry_busy ||
                   (I_OVERTEMP_EVENT && q.mode_cfg[mdcfg_pkg::MT_OT_RESP]);
    d.ripple_latched = (I_RIPPLE_OVER && ripple_field == mdcfg_pkg::RIPPLE_LATCH) ||
                       (q.ripple_latched && !q.clr_count);
    d.ripple_sat = (ripple_field == mdcfg_pkg::RIPPLE_SATURATE);
    d.fault_n = !(ripple_src || stall_src || cbc_src || q.ocp_latched || q.ots_latched);
    // Register bits only reach the bridge when selected
    d.bridge_a = q.report_cfg[mdcfg_pkg::RB_SOURCE] ? q.report_cfg[mdcfg_pkg::RB_INPUT_A] : pins_s[1];
    d.bridge_b = q.report_cfg[mdcfg_pkg::RB_SOURCE] ? q.report_cfg[mdcfg_pkg::RB_INPUT_B] : pins_s[0];
    d.blank_cyc = q.mode_cfg[mdcfg_pkg::MT_BLANK_SEL] ? mdcfg_pkg::BLANK_SHORT_CYC :
                  mdcfg_pkg::BLANK_LONG_CYC;
    d.deg_cyc = q.mode_cfg[mdcfg_pkg::MT_DEGLITCH_SEL] ? mdcfg_pkg::DEGLITCH_SHORT_CYC :
                mdcfg_pkg::DEGLITCH_LONG_CYC;
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.inrush_lo <= mdcfg_pkg::RST_INRUSH_LOW;
      q.inrush_hi <= mdcfg_pkg::RST_INRUSH_HIGH;
      q.mode_cfg <= mdcfg_pkg::RST_MODE_TIMING;
      q.report_cfg <= mdcfg_pkg::RST_REPORT_BRIDGE;
      q.fault_n <= 1'b1;
      q.blank_cyc <= mdcfg_pkg::BLANK_LONG_CYC;
      q.deg_cyc <= mdcfg_pkg::DEGLITCH_LONG_CYC;
    end else begin
      q <= d;
    end
  end

  assign O_SDA_OUT = q.sda_out;
  assign O_SDA_OE = q.sda_oe;
  assign O_FAULT_OUT_N = q.fault_n;
  assign O_BRIDGE_A = q.bridge_a;
  assign O_BRIDGE_B = q.bridge_b;
  assign O_BRIDGE_INPUT_MODE = q.report_cfg[mdcfg_pkg::RB_INPUT_MODE];
  assign O_CURRENT_REG_BEHAVIOUR = q.mode_cfg[mdcfg_pkg::MT_BEHAV_HI:mdcfg_pkg::MT_BEHAV_LO];
  assign O_STALL_RESPONSE_SELECT = q.mode_cfg[mdcfg_pkg::MT_STALL_RESP];
  assign O_INT_VREF = q.mode_cfg[mdcfg_pkg::MT_INT_VREF];
  assign O_SENSE_BLANK_CYCLES = q.blank_cyc;
  assign O_DEGLITCH_CYCLES = q.deg_cyc;
  assign O_STALL_DETECTED = q.stall;
  assign O_BRIDGE_OFF = q.bridge_off;
  assign O_CLEAR_COUNT = q.clr_count;
  assign O_RIPPLE_SATURATE = q.ripple_sat;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  property p_reset_values;
    disable iff (1'b0)
    I_RST |=> (q.mode_cfg == mdcfg_pkg::RST_MODE_TIMING && q.report_cfg == mdcfg_pkg::RST_REPORT_BRIDGE &&
               q.inrush_lo == mdcfg_pkg::RST_INRUSH_LOW && q.inrush_hi == mdcfg_pkg::RST_INRUSH_HIGH);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("config not at reset value");
  property p_inrush_arm;
    (q.inrush_load && {q.inrush_hi, q.inrush_lo} != 16'h0000) |=> inrush_busy;
  endproperty
  a_inrush_arm: assert property (p_inrush_arm) else $error("inrush timer not armed");
  property p_inrush_blank;
    inrush_busy |=> !O_STALL_DETECTED;
  endproperty
  a_inrush_blank: assert property (p_inrush_blank) else $error("stall during inrush");
  property p_start_blank;
    (I_MOTOR_RUN && !q.run_prev) |=> !O_STALL_DETECTED ##1 !O_STALL_DETECTED;
  endproperty
  a_start_blank: assert property (p_start_blank) else $error("stall at motor start");
  property p_blank_sel;
    1'b1 |=> O_SENSE_BLANK_CYCLES == ($past(q.mode_cfg[mdcfg_pkg::MT_BLANK_SEL]) ?
             mdcfg_pkg::BLANK_SHORT_CYC : mdcfg_pkg::BLANK_LONG_CYC);
  endproperty
  a_blank_sel: assert property (p_blank_sel) else $error("blanking count wrong");
  property p_deg_sel;
    1'b1 |=> O_DEGLITCH_CYCLES == ($past(q.mode_cfg[mdcfg_pkg::MT_DEGLITCH_SEL]) ?
             mdcfg_pkg::DEGLITCH_SHORT_CYC : mdcfg_pkg::DEGLITCH_LONG_CYC);
  endproperty
  a_deg_sel: assert property (p_deg_sel) else $error("deglitch count wrong");
  property p_ocp_latch;
    (I_OVERCURRENT_EVENT && !q.mode_cfg[mdcfg_pkg::MT_OC_RESP]) |=> O_BRIDGE_OFF ##1 !O_FAULT_OUT_N;
  endproperty
  a_ocp_latch: assert property (p_ocp_latch) else $error("overcurrent not latched");
  property p_ocp_retry;
    (I_OVERCURRENT_EVENT && q.mode_cfg[mdcfg_pkg::MT_OC_RESP]) |=> O_BRIDGE_OFF ##1 retry_busy;
  endproperty
  a_ocp_retry: assert property (p_ocp_retry) else $error("retry not started");
  property p_ots;
    I_OVERTEMP_EVENT |=> O_BRIDGE_OFF;
  endproperty
  a_ots: assert property (p_ots) else $error("overtemp did not stop bridge");
  property p_clear_faults;
    (q.clr_faults && !I_OVERCURRENT_EVENT && !I_OVERTEMP_EVENT) |=> (!q.ocp_latched && !q.ots_latched);
  endproperty
  a_clear_faults: assert property (p_clear_faults) else $error("faults not cleared");
  property p_ripple_level;
    (ripple_field == mdcfg_pkg::RIPPLE_LEVEL && I_RIPPLE_OVER) |=> !O_FAULT_OUT_N;
  endproperty
  a_ripple_level: assert property (p_ripple_level) else $error("ripple not reported");
  property p_clear_count;
    (q.clr_count && ripple_field == mdcfg_pkg::RIPPLE_LATCH && !I_RIPPLE_OVER) |=> !q.ripple_latched;
  endproperty
  a_clear_count: assert property (p_clear_count) else $error("ripple fault not released");
  property p_stall_report;
    (O_STALL_DETECTED && q.report_cfg[mdcfg_pkg::RB_STALL_REPORT_BIT]) |=> !O_FAULT_OUT_N;
  endproperty
  a_stall_report: assert property (p_stall_report) else $error("stall not reported");
  property p_cbc_report;
    (I_REG_SCHEME == mdcfg_pkg::SCHEME_CBC && q.report_cfg[mdcfg_pkg::RB_CYCLE_REP] && I_CBC_REGULATING)
      |=> !O_FAULT_OUT_N;
  endproperty
  a_cbc_report: assert property (p_cbc_report) else $error("regulation entry not reported");
  property p_fault_release;
    (!ripple_src && !O_STALL_DETECTED && !cbc_src && !q.ocp_latched && !q.ots_latched) |=> O_FAULT_OUT_N;
  endproperty
  a_fault_release: assert property (p_fault_release) else $error("fault held without source");
  property p_reg_bridge;
    q.report_cfg[mdcfg_pkg::RB_SOURCE] |=> (O_BRIDGE_A == $past(q.report_cfg[mdcfg_pkg::RB_INPUT_A]) &&
                                             O_BRIDGE_B == $past(q.report_cfg[mdcfg_pkg::RB_INPUT_B]));
  endproperty
  a_reg_bridge: assert property (p_reg_bridge) else $error("register bits not on bridge");
  property p_pin_bridge;
    !q.report_cfg[mdcfg_pkg::RB_SOURCE] |=> (O_BRIDGE_A == $past(pins_s[1]) && O_BRIDGE_B == $past(pins_s[0]));
  endproperty
  a_pin_bridge: assert property (p_pin_bridge) else $error("pins not on bridge");

  c_write: cover property (q.st == ST_WDATA_ACK && scl_fall);
  c_read: cover property (q.st == ST_RDATA_ACK && scl_rise && sda_s);
  c_retry: cover property (retry_busy ##1 !retry_busy);
  c_stall_fault: cover property (stall_src ##1 !O_FAULT_OUT_N);
endmodule
`default_nettype wire

// *** sim/mdcfg_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module mdcfg_host #(
  parameter logic [6:0] ADDR = 7'h30 // Follower address
) (
  input wire logic clk, // Block clock
  output logic scl, // Serial clock, still outside frames
  output logic sda_oe, // High pulls data low
  input wire logic sda // Resolved data wire
);
  int nacks = 0;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Quarter bit: two clocks, so low and high phases are four clocks each
  task automatic q();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_oe = ~b;
    q();
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
  endtask
  task automatic start();
    sda_oe = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_oe = 1'b1;
    q();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_oe = 1'b0;
    q();
  endtask
  // Read bytes send all ones then a nack; no written byte is all ones here
  task automatic xfer(input logic [7:0] d, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(1'b1, a);
    if (d != 8'hff && a !== 1'b0) nacks++;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({ADDR, 1'b0}, r);
    xfer(ofs, r);
    xfer(d, r);
    stop();
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({ADDR, 1'b0}, r);
    xfer(ofs, r);
    start();
    xfer({ADDR, 1'b1}, r);
    xfer(8'hff, d);
    stop();
  endtask
endmodule
`default_nettype wire

// *** sim/test_motor_driver_config_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_motor_driver_config_regs;
  logic clk = 0, rst = 1, scl, h_oe, sda, d_oe, sda_o, f_n, ba, bb, md, sr, vr, st, bo, cc, sat;
  logic run = 0, sraw = 0, oc = 0, ot = 0, rip = 0, cbc = 0;
  logic [1:0] pins = 2'h0, sch = 2'h0, bh;
  logic [5:0] bl, dg;
  logic [7:0] r;
  int n_errors = 0, cmp_count = 0;
  int cc_n = 0;
  assign sda = ~(h_oe | d_oe);
  initial forever #25 clk = ~clk;
  // Clear-count strobe lasts one cycle, so count it as it passes
  always @(posedge clk) if (cc === 1'b1) cc_n <= cc_n + 1;
  mdcfg_top #(.DEV_ADDR(7'h30), .RETRY_TICKS(16'h0004)) i_dut (.I_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda),
    .I_BRIDGE_INPUT_PINS(pins), .I_MOTOR_RUN(run), .I_STALL_RAW(sraw), .I_OVERCURRENT_EVENT(oc),
    .I_OVERTEMP_EVENT(ot), .I_RIPPLE_OVER(rip), .I_CBC_REGULATING(cbc), .I_REG_SCHEME(sch), .O_SDA_OUT(sda_o),
    .O_SDA_OE(d_oe), .O_FAULT_OUT_N(f_n), .O_BRIDGE_A(ba), .O_BRIDGE_B(bb), .O_BRIDGE_INPUT_MODE(md),
    .O_CURRENT_REG_BEHAVIOUR(bh), .O_STALL_RESPONSE_SELECT(sr), .O_INT_VREF(vr), .O_SENSE_BLANK_CYCLES(bl),
    .O_DEGLITCH_CYCLES(dg), .O_STALL_DETECTED(st), .O_BRIDGE_OFF(bo), .O_CLEAR_COUNT(cc), .O_RIPPLE_SATURATE(sat));
  mdcfg_host #(.ADDR(7'h30)) i_host (.clk(clk), .scl(scl), .sda_oe(h_oe), .sda(sda));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] ofs, input logic [7:0] e);
    i_host.rd(ofs, r);
    chk(r, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end
  initial begin
    cyc(6);
    rst = 0;
    cyc(4);
    rchk(mdcfg_pkg::OFS_INRUSH_LOW, 8'h00);
    rchk(mdcfg_pkg::OFS_INRUSH_HIGH, 8'h00);
    rchk(mdcfg_pkg::OFS_MODE_TIMING, 8'h63);
    rchk(mdcfg_pkg::OFS_REPORT_BRIDGE, 8'h38);
    chk({3'h0, md, bh, sr, vr}, 8'h16);
    chk({2'h0, bl}, {2'h0, mdcfg_pkg::BLANK_LONG_CYC});
    chk({2'h0, dg}, {2'h0, mdcfg_pkg::DEGLITCH_LONG_CYC});
    chk({6'h0, sda_o, sat}, 8'h00);
    i_host.wr(mdcfg_pkg::OFS_MODE_TIMING, 8'h1c);
    cyc(2);
    chk({4'h0, bh, sr, vr}, 8'h01);
    chk({2'h0, bl}, {2'h0, mdcfg_pkg::BLANK_SHORT_CYC});
    chk({2'h0, dg}, {2'h0, mdcfg_pkg::DEGLITCH_SHORT_CYC});
    rchk(mdcfg_pkg::OFS_MODE_TIMING, 8'h1c);
    rchk(8'h20, 8'h00);
    pins = 2'h1;
    i_host.wr(mdcfg_pkg::OFS_REPORT_BRIDGE, 8'h26);
    cyc(2);
    chk({5'h0, md, ba, bb}, 8'h02);
    i_host.wr(mdcfg_pkg::OFS_REPORT_BRIDGE, 8'h22);
    cyc(4);
    chk({6'h0, ba, bb}, 8'h01);
    sraw = 1;
    cyc(3);
    chk({6'h0, st, f_n}, 8'h02);
    sraw = 0;
    cyc(3);
    chk({7'h0, f_n}, 8'h01);
    i_host.wr(mdcfg_pkg::OFS_REPORT_BRIDGE, 8'h02);
    sraw = 1;
    cyc(3);
    chk({6'h0, st, f_n}, 8'h03);
    sraw = 0;
    i_host.wr(mdcfg_pkg::OFS_REPORT_BRIDGE, 8'h10);
    sch = mdcfg_pkg::SCHEME_CBC;
    cbc = 1;
    cyc(2);
    chk({7'h0, f_n}, 8'h00);
    sch = 2'h0;
    cyc(2);
    chk({7'h0, f_n}, 8'h01);
    cbc = 0;
    i_host.wr(mdcfg_pkg::OFS_REPORT_BRIDGE, 8'h80);
    rip = 1;
    cyc(2);
    rip = 0;
    cyc(2);
    chk({7'h0, f_n}, 8'h00);
    i_host.wr(mdcfg_pkg::OFS_CLEAR_CMD, 8'h04);
    cyc(2);
    chk({7'h0, f_n}, 8'h01);
    chk(8'(cc_n), 8'h01);
    i_host.wr(mdcfg_pkg::OFS_REPORT_BRIDGE, 8'h40);
    rip = 1;
    cyc(2);
    chk({6'h0, sat, f_n}, 8'h00);
    i_host.wr(mdcfg_pkg::OFS_REPORT_BRIDGE, 8'hc0);
    chk({6'h0, sat, f_n}, 8'h02);
    rip = 0;
    cyc(2);
    chk({6'h0, sat, f_n}, 8'h03);
    oc = 1;
    cyc(2);
    oc = 0;
    cyc(3);
    chk({6'h0, bo, f_n}, 8'h02);
    i_host.wr(mdcfg_pkg::OFS_CLEAR_CMD, 8'h02);
    cyc(2);
    chk({6'h0, bo, f_n}, 8'h01);
    rchk(mdcfg_pkg::OFS_CLEAR_CMD, 8'h00);
    ot = 1;
    cyc(2);
    ot = 0;
    cyc(3);
    chk({7'h0, bo}, 8'h01);
    i_host.wr(mdcfg_pkg::OFS_CLEAR_CMD, 8'h02);
    i_host.wr(mdcfg_pkg::OFS_MODE_TIMING, 8'h1f);
    oc = 1;
    cyc(2);
    oc = 0;
    chk({7'h0, bo}, 8'h01);
    cyc(50);
    chk({7'h0, bo}, 8'h01);
    cyc(40);
    chk({7'h0, bo}, 8'h00);
    ot = 1;
    cyc(3);
    chk({7'h0, bo}, 8'h01);
    ot = 0;
    cyc(3);
    chk({7'h0, bo}, 8'h00);
    // Ten ticks of blanking, twenty clocks each
    i_host.wr(mdcfg_pkg::OFS_INRUSH_LOW, 8'h0a);
    run = 1;
    sraw = 1;
    cyc(175);
    chk({7'h0, st}, 8'h00);
    cyc(35);
    chk({7'h0, st}, 8'h01);
    chk(8'(cc_n), 8'h01);
    chk(8'(i_host.nacks), 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
